// ### pkg/adc_mux_pkg.sv
// package: register map, field positions and mux source codes for the converter control block
package adc_mux_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
  localparam logic [7:0] ADDR_CONV_CFG = 8'hBC;
  localparam logic [7:0] ADDR_PIN_SEL = 8'hBD;
  localparam logic [7:0] ADDR_RES_LO = 8'hBE;
  localparam logic [7:0] ADDR_RES_HI = 8'hBF;
  localparam logic [7:0] ADDR_CONV_CTL = 8'hE8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PAIR_CFG = 8'h00;
  localparam logic [7:0] RST_CHAN_SEL = 8'h00;
  localparam logic [7:0] RST_CONV_CFG = 8'h00;
  localparam logic [7:0] RST_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_CONV_CTL = 8'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PAIR01_BIT = 0;
  localparam int PAIR23_BIT = 1;
  localparam int HVDIFF_BIT = 2;
  localparam int P3DIFF_BIT = 3;
  localparam logic [7:0] PAIR_CFG_WMASK = 8'h0F;
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 4;
  localparam int BUSY_BIT = 5;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int CHAN_W = 4;
  localparam int RAW_W = 10;

  // gain codes; unity is the reset code
  localparam logic [2:0] GAIN_X1 = 3'h0;
  localparam logic [2:0] GAIN_X2 = 3'h1;
  localparam logic [2:0] GAIN_X4 = 3'h2;
  localparam logic [2:0] GAIN_X8 = 3'h3;
  localparam logic [2:0] GAIN_X16 = 3'h4;
  localparam logic [2:0] GAIN_HALF = 3'h6;

  // ----------------------------------------------------------------
  // mux sources and routing carrier
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_AIN0 = 4'b0000,
    SRC_AIN1 = 4'b0001,
    SRC_AIN2 = 4'b0010,
    SRC_AIN3 = 4'b0011,
    SRC_HVAMP = 4'b0100,
    SRC_AGND = 4'b0101,
    SRC_P3EVEN = 4'b0110,
    SRC_P3ODD = 4'b0111,
    SRC_TEMP = 4'b1000,
    SRC_HVREF = 4'b1001
  } src_t;

  typedef struct packed {
    src_t posSrc;
    src_t negSrc;
    logic diff;
  } route_t;

  localparam route_t RST_ROUTE = '{posSrc: SRC_AIN0, negSrc: SRC_AGND, diff: 1'b0};

endpackage

// ### src/mux_route_decode.sv
// channel select plus pair configuration to positive/negative source decoder
`timescale 1ns/100ps
module mux_route_decode
  import adc_mux_pkg::*;
(
  input wire logic [3:0] chanSel,
  input wire logic [3:0] pairCfg,
  output route_t route
);

  // ----------------------------------------------------------------
  // pairing decode
  // ----------------------------------------------------------------
  // each pairing bit covers both channel codes of its pair
  wire inPair01 = (chanSel == 4'h0) || (chanSel == 4'h1);
  wire inPair23 = (chanSel == 4'h2) || (chanSel == 4'h3);
  wire inPairHv = (chanSel == 4'h4) || (chanSel == 4'h5);
  wire inPairP3 = (chanSel == 4'h6) || (chanSel == 4'h7);
  wire diff01 = inPair01 && pairCfg[PAIR01_BIT];
  wire diff23 = inPair23 && pairCfg[PAIR23_BIT];
  wire diffHv = inPairHv && pairCfg[HVDIFF_BIT];
  wire diffP3 = inPairP3 && pairCfg[P3DIFF_BIT];
  wire anyDiff = diff01 || diff23 || diffHv || diffP3;

  // single-ended source per channel code; codes 8..15 all reach the sensor
  wire src_t seSrc = (chanSel[3]) ? SRC_TEMP : src_t'({1'b0, chanSel[2:0]});

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  wire src_t diffPos = diff01 ? SRC_AIN0 : diff23 ? SRC_AIN2 : diffHv ? SRC_HVAMP : SRC_P3EVEN;
  wire src_t diffNeg = diff01 ? SRC_AIN1 : diff23 ? SRC_AIN3 : diffHv ? SRC_HVREF : SRC_P3ODD;

  assign route.posSrc = anyDiff ? diffPos : seSrc;
  assign route.negSrc = anyDiff ? diffNeg : SRC_AGND;
  assign route.diff = anyDiff;

endmodule

// ### src/adc_input_mux_config.sv
// converter subsystem control: enable, mux pairing, gain and result formatting behind the sfr port
`timescale 1ns/100ps
// Function
// - converter blocks run only while enable set
// - nine selectable channels, one 10-bit converter
// - all pairs single-ended after reset
// - software sets pairs differential without reset
// - three-bit gain field in configuration register
// - gains half, one, two, four, eight, sixteen
// - gain is unity after reset
// - any port 3 pin combination selectable
// - even pins one input, odd another
// - high-voltage amplifier selectable like any channel
// - temperature sensor is a selectable source
// - differential results in two's complement
module adc_input_mux_config
  import adc_mux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  input wire logic [9:0] convRaw,
  input wire logic convDone,
  output logic subsysOn,
  output logic convStart,
  output logic [2:0] gainCode,
  output route_t muxRoute,
  output logic [7:0] pinAnalogEn,
  output logic [15:0] resultWord,
  output logic resultDiff
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] pairCfg_q;
  logic [7:0] chanSel_q;
  logic [7:0] convCfg_q;
  logic [7:0] pinSel_q;
  logic convEn_q;
  logic busy_q;
  logic convStart_q;
  logic [15:0] result_q;
  logic resultDiff_q;
  route_t route_q;
  logic [7:0] rdData_q;
  route_t routeNext;

  // address compare, shared by the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wrPair = sfrWrEn && hit(sfrAddr, ADDR_PAIR_CFG);
  wire wrChan = sfrWrEn && hit(sfrAddr, ADDR_CHAN_SEL);
  wire wrCfg = sfrWrEn && hit(sfrAddr, ADDR_CONV_CFG);
  wire wrPin = sfrWrEn && hit(sfrAddr, ADDR_PIN_SEL);
  wire wrCtl = sfrWrEn && hit(sfrAddr, ADDR_CONV_CTL);

  // start is only honoured when the same write sets enable and the converter is idle
  wire enNext = wrCtl ? sfrWrData[ENABLE_BIT] : convEn_q;
  wire startReq = wrCtl && sfrWrData[START_BIT] && sfrWrData[ENABLE_BIT] && !busy_q;
  // a done from a powered-down converter is stale and dropped
  wire takeResult = convDone && convEn_q && busy_q;

  // offset binary to two's complement: flip the msb, extend the sign
  wire [15:0] seWord = {6'h00, convRaw};
  wire [15:0] diffWord = {{6{~convRaw[9]}}, ~convRaw[9], convRaw[8:0]};
  wire [15:0] resultNext = route_q.diff ? diffWord : seWord;

  // control register readback shows live busy state
  wire [7:0] ctlRead = {convEn_q, 1'b0, busy_q, 5'h00};

  // reserved pair bits read as zero
  wire [7:0] rdMux =
    hit(sfrAddr, ADDR_PAIR_CFG) ? (pairCfg_q & PAIR_CFG_WMASK) :
    hit(sfrAddr, ADDR_CHAN_SEL) ? chanSel_q :
    hit(sfrAddr, ADDR_CONV_CFG) ? convCfg_q :
    hit(sfrAddr, ADDR_PIN_SEL) ? pinSel_q :
    hit(sfrAddr, ADDR_RES_LO) ? result_q[7:0] :
    hit(sfrAddr, ADDR_RES_HI) ? result_q[15:8] :
    hit(sfrAddr, ADDR_CONV_CTL) ? ctlRead : 8'h00;

  // routing follows the live registers; registered one cycle later
  mux_route_decode u_mux_route_decode
  (
    .chanSel(chanSel_q[CHAN_W-1:0]),
    .pairCfg(pairCfg_q[3:0]),
    .route(routeNext)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // pairing writes take effect on the next edge, no reset needed
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pairCfg_q <= RST_PAIR_CFG;
    else if (wrPair)
      pairCfg_q <= sfrWrData & PAIR_CFG_WMASK;
  end

  // channel and pin selection
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chanSel_q <= RST_CHAN_SEL;
      pinSel_q <= RST_PIN_SEL;
    end
    else
    begin
      if (wrChan)
        chanSel_q <= sfrWrData;
      if (wrPin)
        pinSel_q <= sfrWrData;
    end
  end

  // gain field lives in the low bits of the configuration register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      convCfg_q <= RST_CONV_CFG;
    else if (wrCfg)
      convCfg_q <= sfrWrData;
  end

  // ----------------------------------------------------------------
  // enable and conversion sequencing
  // ----------------------------------------------------------------
  // clearing enable also abandons any conversion in flight
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      convEn_q <= 1'b0;
      busy_q <= 1'b0;
      convStart_q <= 1'b0;
    end
    else
    begin
      convEn_q <= enNext;
      convStart_q <= startReq;
      if (!enNext)
        busy_q <= 1'b0;
      else if (startReq)
        busy_q <= 1'b1;
      else if (takeResult)
        busy_q <= 1'b0;
    end
  end

  // result capture keeps the format of the route it was taken on
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      result_q <= RST_RESULT;
      resultDiff_q <= 1'b0;
    end
    else if (takeResult)
    begin
      result_q <= resultNext;
      resultDiff_q <= route_q.diff;
    end
  end

  // route and read data registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      route_q <= RST_ROUTE;
      rdData_q <= 8'h00;
    end
    else
    begin
      route_q <= routeNext;
      rdData_q <= sfrRdEn ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // gain and enables straight from flops; only subsysOn signals shutdown, pin enables and route stay live while off
  assign subsysOn = convEn_q;
  assign convStart = convStart_q;
  assign gainCode = convCfg_q[GAIN_LSB +: GAIN_W];
  assign muxRoute = route_q;
  // bits 0,2,4,6 join the even input, 1,3,5,7 the odd; shorting is analog
  assign pinAnalogEn = pinSel_q;
  assign resultWord = result_q;
  assign resultDiff = resultDiff_q;
  assign sfrRdData = rdData_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_off_no_start: assert property (!subsysOn |-> !convStart)
    else $error("start issued while subsystem off");

  a_disable_kills_busy: assert property (wrCtl && !sfrWrData[ENABLE_BIT] |=> !busy_q && !subsysOn)
    else $error("disable did not stop converter");

  a_reset_single_end: assert property ($fell(reset) |-> !muxRoute.diff && gainCode == GAIN_X1)
    else $error("reset state not single-ended unity");

  a_pair01_diff: assert property (wrPair && sfrWrData[PAIR01_BIT] && !wrChan && chanSel_q == 8'h00
    ##1 !wrChan |=> muxRoute.diff && muxRoute.posSrc == SRC_AIN0 && muxRoute.negSrc == SRC_AIN1)
    else $error("pair 0/1 not differential after write");

  a_gain_write: assert property (wrCfg |=> gainCode == $past(sfrWrData[2:0]))
    else $error("gain field did not follow write");

  a_temp_select: assert property (chanSel_q[3] && !wrChan |=> muxRoute.posSrc == SRC_TEMP && !muxRoute.diff)
    else $error("sensor channel not routed");

  a_hv_pairing: assert property (chanSel_q == 8'h04 && pairCfg_q[HVDIFF_BIT] && !wrChan && !wrPair
    |=> muxRoute.negSrc == SRC_HVREF)
    else $error("amplifier not paired against reference");

  a_p3_pairing: assert property (chanSel_q == 8'h06 && pairCfg_q[P3DIFF_BIT] && !wrChan && !wrPair
    |=> muxRoute.posSrc == SRC_P3EVEN && muxRoute.negSrc == SRC_P3ODD)
    else $error("port 3 pair polarity wrong");

  a_diff_twos: assert property (takeResult && route_q.diff
    |=> resultWord[15] == !$past(convRaw[9]) && resultWord[8:0] == $past(convRaw[8:0]))
    else $error("differential result not two's complement");

  a_se_unsigned: assert property (takeResult && !route_q.diff |=> resultWord[15:10] == 6'h00)
    else $error("single-ended result carries sign");

  a_pin_select: assert property (wrPin |=> pinAnalogEn == $past(sfrWrData))
    else $error("pin selection not applied");

  c_diff_result: cover property (takeResult && route_q.diff);
  c_start_done: cover property (convStart ##[1:50] takeResult);
  c_temp_route: cover property (muxRoute.posSrc == SRC_TEMP);
  c_gain_sixteen: cover property (gainCode == GAIN_X16 && subsysOn);

endmodule

// ### sim/conv_model.sv
// behavioural converter core that answers start pulses with a done pulse and a raw word
`timescale 1ns/100ps
module conv_model
(
  input wire logic sys_clk,
  input wire logic convStart,
  input wire logic [3:0] latency,
  input wire logic [9:0] rawVal,
  output logic convDone,
  output logic [9:0] convRaw
);
  int cnt = 0;
  initial
  begin
    convDone = 1'b0;
    convRaw = 10'h155;
  end
  // ----------------------------------------------------------------
  // countdown from start to done
  // ----------------------------------------------------------------
  // raw word toggles outside the done cycle, so stale data never looks valid
  always @(posedge sys_clk)
  begin
    convDone <= 1'b0;
    convRaw <= ~convRaw;
    if (convStart)
      cnt <= latency + 1;
    else if (cnt == 1)
    begin
      convDone <= 1'b1;
      convRaw <= rawVal;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_top;
  import adc_mux_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdData;
  logic [9:0] convRaw;
  logic convDone;
  logic subsysOn;
  logic convStart;
  logic [2:0] gainCode;
  route_t muxRoute;
  logic [7:0] pinAnalogEn;
  logic [15:0] resultWord;
  logic resultDiff;
  logic [3:0] latency = 4'h0;
  logic [9:0] rawVal = 10'h000;
  int nMismatch = 0;
  int checked = 0;
  logic [7:0] d;

  always #20 sys_clk = ~sys_clk;

  adc_input_mux_config u_adc_input_mux_config (.sys_clk(sys_clk), .reset(reset), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .convRaw(convRaw),
    .convDone(convDone), .subsysOn(subsysOn), .convStart(convStart), .gainCode(gainCode),
    .muxRoute(muxRoute), .pinAnalogEn(pinAnalogEn), .resultWord(resultWord), .resultDiff(resultDiff));
  conv_model u_conv_model (.sys_clk(sys_clk), .convStart(convStart), .latency(latency), .rawVal(rawVal),
    .convDone(convDone), .convRaw(convRaw));

  // ----------------------------------------------------------------
  // bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWrEn <= 1'b1;
    @(posedge sys_clk);
    sfrWrEn <= 1'b0;
  endtask

  // read data stands one cycle only, so it is taken just after the edge that loads it
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge sys_clk);
    sfrRdEn <= 1'b0;
    #1 v = sfrRdData;
  endtask

  task automatic finish_test();
    if (nMismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] addrs [8] = '{ADDR_PAIR_CFG, ADDR_CHAN_SEL, ADDR_CONV_CFG, ADDR_PIN_SEL, ADDR_CONV_CTL,
      ADDR_RES_LO, ADDR_RES_HI, 8'h00};
    #1 check({15'h0000, subsysOn}, 16'h0000);
    check({13'h0000, gainCode}, 16'h0000);
    check({7'h00, muxRoute}, {7'h00, RST_ROUTE});
    check({8'h00, pinAnalogEn}, 16'h0000);
    check(resultWord, RST_RESULT);
    foreach (addrs[i])
    begin
      rd(addrs[i], d);
      check({8'h00, d}, 16'h0000);
    end
  endtask

  // pairing table: {pair config, channel, expected route}
  task automatic t_pairs();
    logic [16:0] tbl [8] = '{{4'h1, 4'h0, SRC_AIN0, SRC_AIN1, 1'b1}, {4'h2, 4'h2, SRC_AIN2, SRC_AIN3, 1'b1},
      {4'h4, 4'h4, SRC_HVAMP, SRC_HVREF, 1'b1}, {4'h8, 4'h6, SRC_P3EVEN, SRC_P3ODD, 1'b1},
      {4'h0, 4'h4, SRC_HVAMP, SRC_AGND, 1'b0}, {4'h0, 4'h7, SRC_P3ODD, SRC_AGND, 1'b0},
      {4'h7, 4'h8, SRC_TEMP, SRC_AGND, 1'b0}, {4'h2, 4'h1, SRC_AIN1, SRC_AGND, 1'b0}};
    wr(ADDR_PAIR_CFG, 8'hFF);
    rd(ADDR_PAIR_CFG, d);
    check({8'h00, d}, 16'h000F);
    foreach (tbl[i])
    begin
      wr(ADDR_PAIR_CFG, {4'h0, tbl[i][16:13]});
      wr(ADDR_CHAN_SEL, {4'h0, tbl[i][12:9]});
      repeat (2) @(posedge sys_clk);
      #1 check({7'h00, muxRoute}, {7'h00, tbl[i][8:0]});
    end
  endtask

  task automatic t_gain();
    logic [2:0] codes [6] = '{GAIN_HALF, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X1};
    foreach (codes[i])
    begin
      wr(ADDR_CONV_CFG, {5'h00, codes[i]});
      #1 check({13'h0000, gainCode}, {13'h0000, codes[i]});
      rd(ADDR_CONV_CFG, d);
      check({13'h0000, d[2:0]}, {13'h0000, codes[i]});
    end
  endtask

  task automatic t_pins(input logic [7:0] v);
    wr(ADDR_PIN_SEL, v);
    #1 check({8'h00, pinAnalogEn}, {8'h00, v});
    rd(ADDR_PIN_SEL, d);
    check({8'h00, d}, {8'h00, v});
  endtask

  task automatic t_conv(input logic [3:0] cfg, input logic [3:0] ch, input logic [3:0] lat,
    input logic [9:0] raw, input logic [15:0] expWord, input logic expDiff);
    int n;
    latency <= lat;
    rawVal <= raw;
    wr(ADDR_PAIR_CFG, {4'h0, cfg});
    wr(ADDR_CHAN_SEL, {4'h0, ch});
    wr(ADDR_CONV_CTL, 8'h90);
    #1 check({14'h0000, subsysOn, convStart}, 16'h0003);
    n = 0;
    while (convDone !== 1'b1)
    begin
      @(posedge sys_clk);
      #1 n++;
      if (n > 40)
      begin
        nMismatch++;
        finish_test();
      end
    end
    @(posedge sys_clk);
    #1 check(resultWord, expWord);
    check({15'h0000, resultDiff}, {15'h0000, expDiff});
    rd(ADDR_RES_LO, d);
    check({8'h00, d}, {8'h00, expWord[7:0]});
    rd(ADDR_RES_HI, d);
    check({8'h00, d}, {8'h00, expWord[15:8]});
    rd(ADDR_CONV_CTL, d);
    check({8'h00, d}, 16'h0080);
  endtask

  // start with enable clear must leave the converter shut down; unmapped writes vanish
  task automatic t_refuse();
    wr(ADDR_CONV_CTL, 8'h10);
    repeat (3)
    begin
      #1 check({14'h0000, subsysOn, convStart}, 16'h0000);
      @(posedge sys_clk);
    end
    wr(8'h00, 8'hFF);
    rd(8'h00, d);
    check({8'h00, d}, 16'h0000);
  endtask

  // busy refuses a second start; clearing enable drops the conversion and its late done
  // raw zero on the still-differential route would give fe00, so a taken stale done shows up
  task automatic t_abort();
    latency <= 4'hF;
    rawVal <= 10'h000;
    wr(ADDR_CONV_CTL, 8'h90);
    #1 check({14'h0000, subsysOn, convStart}, 16'h0003);
    wr(ADDR_CONV_CTL, 8'h90);
    #1 check({14'h0000, subsysOn, convStart}, 16'h0002);
    rd(ADDR_CONV_CTL, d);
    check({8'h00, d}, 16'h00A0);
    wr(ADDR_CONV_CTL, 8'h00);
    #1 check({15'h0000, subsysOn}, 16'h0000);
    repeat (20) @(posedge sys_clk);
    #1 check(resultWord, 16'h01FF);
    check({15'h0000, resultDiff}, 16'h0001);
    rd(ADDR_CONV_CTL, d);
    check({8'h00, d}, 16'h0000);
  endtask

  // a second reset mid-run must undo every configuration write
  task automatic t_midreset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_pairs();
    t_gain();
    t_pins(8'hA5);
    t_pins(8'h5A);
    t_conv(4'h0, 4'h1, 4'h0, 10'h2A5, 16'h02A5, 1'b0);
    t_conv(4'h1, 4'h0, 4'h9, 10'h000, 16'hFE00, 1'b1);
    t_conv(4'h8, 4'h6, 4'h3, 10'h3FF, 16'h01FF, 1'b1);
    t_abort();
    t_refuse();
    t_midreset();
    finish_test();
  end
endmodule
